/* File: hdl/bpb_pkg.sv */
// shared constants for the bidirectional port bank
package bpb_pkg;
    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned PORT_W      = 8;
    localparam int unsigned NUM_PORTS   = 3;
    localparam int unsigned NUM_WAKE    = 2;
    localparam int unsigned PORT_L      = 0;
    localparam int unsigned PORT_M      = 1;
    localparam int unsigned PORT_G      = 2;
    // per-port register layout, byte offsets inside one port slot
    localparam logic [7:0] OFS_CFG      = 8'h00;
    localparam logic [7:0] OFS_DATA     = 8'h04;
    localparam logic [7:0] OFS_PINS     = 8'h08;
    localparam logic [7:0] OFS_WAKE_EN  = 8'h0C;
    localparam logic [7:0] OFS_WAKE_EDG = 8'h10;
    localparam logic [7:0] OFS_WAKE_PND = 8'h14;
    localparam logic [7:0] OFS_ALT_SEL  = 8'h18;
    localparam logic [7:0] BASE_L       = 8'h00;
    localparam logic [7:0] BASE_M       = 8'h20;
    localparam logic [7:0] BASE_G       = 8'h40;
    localparam logic [7:0] SLOT_MASK    = 8'hE0;
    localparam logic [7:0] REG_MASK     = 8'h1F;
    // special port bit positions
    localparam int unsigned G_IN_BIT    = 6;
    localparam int unsigned G_CLK_BIT   = 7;
    localparam int unsigned G_IDLE_BIT  = 6;
    localparam int unsigned G_HALT_BIT  = 7;
    localparam int unsigned G_ALT_PH    = 6;
    localparam int unsigned G_CLK_DLY   = 7;
    localparam logic [7:0] G_DATA_MASK  = 8'h3F;
    // serial alternate pins on the first wakeup port
    localparam int unsigned L_CLK_BIT   = 1;
    localparam int unsigned L_TX_BIT    = 2;
    localparam int unsigned L_RX_BIT    = 3;
    localparam logic [7:0] ALT_MASK     = 8'h0E;
    // reset values
    localparam logic [7:0] RST_CFG      = 8'h00;
    localparam logic [7:0] RST_DATA     = 8'h00;
    localparam logic [7:0] RST_WAKE     = 8'h00;
    localparam logic [7:0] RST_ALT      = 8'h00;

    typedef struct packed {
        logic [NUM_PORTS-1:0][PORT_W-1:0] cfg;
        logic [NUM_PORTS-1:0][PORT_W-1:0] data;
        logic [NUM_WAKE-1:0][PORT_W-1:0]  wen;
        logic [NUM_WAKE-1:0][PORT_W-1:0]  wedge;
        logic [NUM_WAKE-1:0][PORT_W-1:0]  wpend;
        logic [NUM_WAKE-1:0][PORT_W-1:0]  prev;
        logic [PORT_W-1:0]                alt;
        logic [PORT_W-1:0]                rdata;
        logic                             ack;
        logic                             halt;
        logic                             idle;
    } bpb_state_t;
endpackage : bpb_pkg

/* File: hdl/bpb_port_bank.sv */
// three memory-mapped bidirectional ports behind an Avalon-MM slave
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - cfg/data 00 hi-z, 01 pulled-up input, 10 drive low, 11 drive high
// - every bit of both wakeup ports and special port bits 0-5 is set on its own by software
// - each port has direction register, output latch and a pin-level read
// - all eight pins of both wakeup ports detect wakeup edges
// - wakeups from both ports share one wakeup request output
// - first wakeup port pins 3,2,1 carry serial receive, transmit, clock
// - special port bits 0-5 bidirectional, bit 6 input only, bit 7 output
// - special port bit 7 always drives the oscillator clock out
// - special bits 6 and 7 of cfg and data are control, not pin control
// - special port data bits 6 and 7 always read as zero
// - writing one to special data bit 7 requests full stop mode
// - writing one to special data bit 6 requests light sleep mode
// - an alternate function overrides the pin's cfg and data bits
// - special cfg bit 6 selects the alternate shift clock phase
module bpb_port_bank
    import bpb_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    // first wakeup port pins
    input  wire logic [7:0]        pin_l_in,
    output logic [7:0]             pin_l_out,
    output logic [7:0]             pin_l_oe,
    output logic [7:0]             pin_l_pu,
    // second wakeup port pins
    input  wire logic [7:0]        pin_m_in,
    output logic [7:0]             pin_m_out,
    output logic [7:0]             pin_m_oe,
    output logic [7:0]             pin_m_pu,
    // special port pins
    input  wire logic [7:0]        pin_g_in,
    output logic [7:0]             pin_g_out,
    output logic [7:0]             pin_g_oe,
    output logic [7:0]             pin_g_pu,
    // serial unit alternate functions
    output logic                   serial_receive_in,
    input  wire logic              serial_transmit_out,
    input  wire logic              serial_clock_out,
    input  wire logic              serial_clock_oe,
    output logic                   serial_clock_pin,
    // clock, power and wakeup controls
    input  wire logic              oscillator_clock_in,
    output logic                   shift_clock_alt_phase,
    output logic                   clock_delay_sel,
    output logic                   halt_req,
    output logic                   idle_req,
    output logic                   multi_pin_wakeup
);

    bpb_state_t s_reg;
    bpb_state_t s_next;
    logic [NUM_PORTS-1:0][PORT_W-1:0] pins;
    logic                             req;
    logic [7:0]                       slot;
    logic [7:0]                       ofs;
    logic [PORT_W-1:0]                rd_val;

    assign pins = {pin_g_in, pin_m_in, pin_l_in};
    assign req  = avs_read | avs_write;
    assign slot = avs_address & SLOT_MASK;
    assign ofs  = avs_address & REG_MASK;

    // read multiplexer, unmapped reads give zero
    always_comb
    begin
        rd_val = 8'h00;
        if (slot == BASE_L || slot == BASE_M)
        begin
            case (ofs)
                OFS_CFG:      rd_val = s_reg.cfg[slot[5]];
                OFS_DATA:     rd_val = s_reg.data[slot[5]];
                OFS_PINS:     rd_val = pins[slot[5]];
                OFS_WAKE_EN:  rd_val = s_reg.wen[slot[5]];
                OFS_WAKE_EDG: rd_val = s_reg.wedge[slot[5]];
                OFS_WAKE_PND: rd_val = s_reg.wpend[slot[5]];
                OFS_ALT_SEL:  rd_val = (slot == BASE_L) ? s_reg.alt : 8'h00;
                default:      rd_val = 8'h00;
            endcase
        end
        else if (slot == BASE_G)
        begin
            case (ofs)
                OFS_CFG:  rd_val = s_reg.cfg[PORT_G];
                OFS_DATA: rd_val = s_reg.data[PORT_G] & G_DATA_MASK;
                OFS_PINS: rd_val = pins[PORT_G];
                default:  rd_val = 8'h00;
            endcase
        end
    end

    // next state: bus handshake, register writes, wakeup capture
    always_comb
    begin
        logic [NUM_WAKE-1:0][PORT_W-1:0] clr;
        logic [NUM_WAKE-1:0][PORT_W-1:0] ev;
        logic                            wr;
        s_next = s_reg;
        clr    = '0;
        ev     = '0;
        s_next.halt = 1'b0;
        s_next.idle = 1'b0;
        wr = s_reg.ack & avs_write & avs_byteenable[0];
        if (req & ~s_reg.ack)
        begin
            s_next.ack   = 1'b1;
            s_next.rdata = rd_val;
        end
        else
        begin
            s_next.ack = 1'b0;
        end
        if (wr && (slot == BASE_L || slot == BASE_M))
        begin
            case (ofs)
                OFS_CFG:      s_next.cfg[slot[5]] = avs_writedata[7:0];
                OFS_DATA:     s_next.data[slot[5]] = avs_writedata[7:0];
                OFS_WAKE_EN:  s_next.wen[slot[5]] = avs_writedata[7:0];
                OFS_WAKE_EDG: s_next.wedge[slot[5]] = avs_writedata[7:0];
                OFS_WAKE_PND: clr[slot[5]] = avs_writedata[7:0];
                OFS_ALT_SEL:
                begin
                    if (slot == BASE_L)
                        s_next.alt = avs_writedata[7:0] & ALT_MASK;
                end
                default:      s_next.alt = s_reg.alt;
            endcase
        end
        else if (wr && slot == BASE_G)
        begin
            case (ofs)
                OFS_CFG: s_next.cfg[PORT_G] = avs_writedata[7:0];
                OFS_DATA:
                begin
                    s_next.data[PORT_G] = avs_writedata[7:0] & G_DATA_MASK;
                    s_next.halt = avs_writedata[G_HALT_BIT];
                    s_next.idle = avs_writedata[G_IDLE_BIT];
                end
                default: s_next.alt = s_reg.alt;
            endcase
        end
        // edge select 0 rising, 1 falling; a new event beats a clear
        for (int p = 0; p < NUM_WAKE; p++)
        begin
            ev[p] = (pins[p] ^ s_reg.prev[p]) & (pins[p] ^ s_reg.wedge[p]);
            s_next.prev[p]  = pins[p];
            s_next.wpend[p] = (s_reg.wpend[p] & ~clr[p]) | ev[p];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_reg       <= '0;
            s_reg.cfg   <= {NUM_PORTS{RST_CFG}};
            s_reg.data  <= {NUM_PORTS{RST_DATA}};
            s_reg.wen   <= {NUM_WAKE{RST_WAKE}};
            s_reg.wedge <= {NUM_WAKE{RST_WAKE}};
            s_reg.alt   <= RST_ALT;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // pin drivers from the latched cfg and data bits
    always_comb
    begin
        pin_l_oe  = s_reg.cfg[PORT_L];
        pin_l_out = s_reg.data[PORT_L];
        pin_l_pu  = ~s_reg.cfg[PORT_L] & s_reg.data[PORT_L];
        pin_m_oe  = s_reg.cfg[PORT_M];
        pin_m_out = s_reg.data[PORT_M];
        pin_m_pu  = ~s_reg.cfg[PORT_M] & s_reg.data[PORT_M];
        pin_g_oe  = s_reg.cfg[PORT_G] & G_DATA_MASK;
        pin_g_out = s_reg.data[PORT_G] & G_DATA_MASK;
        pin_g_pu  = ~s_reg.cfg[PORT_G] & s_reg.data[PORT_G] & G_DATA_MASK;
        pin_g_oe[G_CLK_BIT]  = 1'b1;
        pin_g_out[G_CLK_BIT] = oscillator_clock_in;
        if (s_reg.alt[L_RX_BIT])
        begin
            pin_l_oe[L_RX_BIT] = 1'b0;
            pin_l_pu[L_RX_BIT] = 1'b0;
        end
        if (s_reg.alt[L_TX_BIT])
        begin
            pin_l_oe[L_TX_BIT]  = 1'b1;
            pin_l_out[L_TX_BIT] = serial_transmit_out;
            pin_l_pu[L_TX_BIT]  = 1'b0;
        end
        if (s_reg.alt[L_CLK_BIT])
        begin
            pin_l_oe[L_CLK_BIT]  = serial_clock_oe;
            pin_l_out[L_CLK_BIT] = serial_clock_out;
            pin_l_pu[L_CLK_BIT]  = 1'b0;
        end
    end

    assign serial_receive_in     = pin_l_in[L_RX_BIT];
    assign serial_clock_pin      = pin_l_in[L_CLK_BIT];
    assign shift_clock_alt_phase = s_reg.cfg[PORT_G][G_ALT_PH];
    assign clock_delay_sel       = s_reg.cfg[PORT_G][G_CLK_DLY];
    assign halt_req              = s_reg.halt;
    assign idle_req              = s_reg.idle;
    assign multi_pin_wakeup      =
        |((s_reg.wpend[PORT_L] & s_reg.wen[PORT_L])
        | (s_reg.wpend[PORT_M] & s_reg.wen[PORT_M]));
    assign avs_waitrequest       = req & ~s_reg.ack;
    assign avs_readdata          = {24'h000000, s_reg.rdata};

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    a_pullup_mode: assert property (
        pin_m_pu == (~pin_m_oe & pin_m_out))
        else $error("pull-up not tied to cfg 0 data 1");
    a_data_applies: assert property (
        ~avs_waitrequest && avs_write && avs_byteenable[0]
        && avs_address == (BASE_M | OFS_DATA)
        |=> pin_m_out == $past(avs_writedata[7:0]))
        else $error("port data write not on pins next cycle");
    a_pin_read: assert property (
        avs_read && !avs_waitrequest && avs_address == (BASE_L | OFS_PINS)
        |-> avs_readdata[7:0] == $past(pin_l_in))
        else $error("pin read does not return pin levels");
    a_wake_capture: assert property (
        pin_m_in[0] && !s_reg.prev[PORT_M][0] && !s_reg.wedge[PORT_M][0]
        |=> s_reg.wpend[PORT_M][0])
        else $error("rising wakeup edge not captured");
    a_shared_wake: assert property (
        (s_reg.wen[PORT_L][0] && s_reg.wpend[PORT_L][0])
        || (s_reg.wen[PORT_M][7] && s_reg.wpend[PORT_M][7])
        |-> multi_pin_wakeup)
        else $error("wakeup not on shared output");
    a_tx_override: assert property (
        s_reg.alt[L_TX_BIT] |-> pin_l_oe[L_TX_BIT]
        && pin_l_out[L_TX_BIT] == serial_transmit_out)
        else $error("transmit alternate not driving pin");
    a_clock_out: assert property (
        pin_g_oe[G_CLK_BIT] && !pin_g_oe[G_IN_BIT]
        && pin_g_out[G_CLK_BIT] == oscillator_clock_in)
        else $error("special port bit 6 or 7 wrong");
    a_gdata_zero: assert property (
        avs_read && !avs_waitrequest && avs_address == (BASE_G | OFS_DATA)
        |-> avs_readdata[7:6] == 2'b00)
        else $error("special data bits 6 7 not zero");
    a_halt_entry: assert property (
        !avs_waitrequest && avs_write && avs_byteenable[0]
        && avs_address == (BASE_G | OFS_DATA) && avs_writedata[G_HALT_BIT]
        |=> halt_req ##1 !halt_req)
        else $error("halt request not one pulse");
    a_idle_entry: assert property (
        $rose(idle_req)
        |-> $past(avs_write && avs_writedata[G_IDLE_BIT]))
        else $error("idle request without write");
    a_alt_phase: assert property (
        $changed(shift_clock_alt_phase) |-> $past(avs_write))
        else $error("shift clock phase changed without write");

    c_read_pins: cover property (avs_read ##1 !avs_waitrequest);
    c_wakeup: cover property ($rose(multi_pin_wakeup));
    c_halt: cover property (halt_req);
    c_serial_alt: cover property (s_reg.alt == ALT_MASK);

endmodule : bpb_port_bank

`default_nettype wire

/* File: test/bpb_board_pin.sv */
// board-side model of one 8-bit port: resolves each wire's level
`timescale 1ns/10ps
`default_nettype none

module bpb_board_pin
(
    // clock
    input  wire logic       core_clk,
    // board drive
    input  wire logic [7:0] drv_val,
    input  wire logic [7:0] drv_en,
    // device side of the pins
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pin_pu,
    output logic [7:0]      pin_in
);
    logic toggle_reg = 1'b0;

    // floating wires wander every cycle instead of holding a level
    always_ff @(posedge core_clk)
    begin
        toggle_reg <= ~toggle_reg;
    end

    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (drv_en[i])
                pin_in[i] = drv_val[i];
            else if (pin_pu[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = toggle_reg ^ i[0];
        end
    end
endmodule : bpb_board_pin
`default_nettype wire

/* File: test/bidirectional_port_bank_tb.sv */
// self-checking bench for the port bank over its register bus
`timescale 1ns/10ps
`default_nettype none

module bidirectional_port_bank_tb;
    import bpb_pkg::*;
    logic              core_clk = 1'b0;
    logic              arst_n;
    logic [7:0]        avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [31:0]       avs_writedata;
    logic [3:0]        avs_byteenable;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic [2:0][7:0]   pin_in;
    logic [2:0][7:0]   pin_out;
    logic [2:0][7:0]   pin_oe;
    logic [2:0][7:0]   pin_pu;
    logic [2:0][7:0]   drv_val;
    logic [2:0][7:0]   drv_en;
    logic [2:0][7:0]   bases;
    logic              srx;
    logic              stx;
    logic              sck_out;
    logic              sck_oe;
    logic              sck_pin;
    logic              osc = 1'b0;
    logic              alt_ph;
    logic              clk_dly;
    logic              halt_req;
    logic              idle_req;
    logic              wake;
    logic [31:0]       q;
    logic [7:0]        m;
    int                miscompares = 0;
    int                cmp_count = 0;

    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) osc <= ~osc;

    bpb_port_bank u_bpb_port_bank (.core_clk(core_clk), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .pin_l_in(pin_in[0]), .pin_l_out(pin_out[0]),
        .pin_l_oe(pin_oe[0]), .pin_l_pu(pin_pu[0]),
        .pin_m_in(pin_in[1]), .pin_m_out(pin_out[1]),
        .pin_m_oe(pin_oe[1]), .pin_m_pu(pin_pu[1]),
        .pin_g_in(pin_in[2]), .pin_g_out(pin_out[2]),
        .pin_g_oe(pin_oe[2]), .pin_g_pu(pin_pu[2]),
        .serial_receive_in(srx), .serial_transmit_out(stx),
        .serial_clock_out(sck_out), .serial_clock_oe(sck_oe),
        .serial_clock_pin(sck_pin), .oscillator_clock_in(osc),
        .shift_clock_alt_phase(alt_ph), .clock_delay_sel(clk_dly),
        .halt_req(halt_req), .idle_req(idle_req),
        .multi_pin_wakeup(wake));

    for (genvar p = 0; p < 3; p++)
    begin : g_board
        bpb_board_pin u_bpb_board_pin (.core_clk(core_clk),
            .drv_val(drv_val[p]), .drv_en(drv_en[p]),
            .pin_out(pin_out[p]), .pin_oe(pin_oe[p]),
            .pin_pu(pin_pu[p]), .pin_in(pin_in[p]));
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected reg t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_reg

    task automatic check_pin(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected pins t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_pin

    task automatic check_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected bit t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_bit

    // one bus cycle; waitrequest and read data taken at the rising edge
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [7:0] d, input logic [3:0] be);
        int   n;
        logic done;
        @(posedge core_clk);
        avs_address    <= a;
        avs_writedata  <= {24'h000000, d};
        avs_byteenable <= be;
        avs_read       <= ~wr;
        avs_write      <= wr;
        done = 1'b0;
        n = 0;
        while (!done && n < 50)
        begin
            @(posedge core_clk);
            done = (avs_waitrequest === 1'b0);
            q = avs_readdata;
            n++;
        end
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (!done)
        begin
            miscompares++;
            $display("unexpected timeout t=%0t got=%h exp=%h",
                     $time, avs_waitrequest, 1'b0);
        end
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, 4'hF);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        xfer(1'b0, a, 8'h00, 4'hF);
        check_reg(q, {24'h000000, exp});
    endtask : rd

    // every pin of one wakeup port changes in the chosen direction
    task automatic wake_test(input int p, input logic [7:0] edg,
                             input logic [7:0] from, input logic [7:0] to);
        drv_val[p] <= from;
        wr(bases[p] + OFS_CFG, 8'h00);
        wr(bases[p] + OFS_DATA, 8'h00);
        wr(bases[p] + OFS_WAKE_PND, 8'hFF);
        wr(bases[p] + OFS_WAKE_EDG, edg);
        wr(bases[p] + OFS_WAKE_EN, 8'hFF);
        @(negedge core_clk);
        check_bit(wake, 1'b0);
        @(posedge core_clk);
        drv_val[p] <= to;
        repeat (4) @(negedge core_clk);
        check_bit(wake, 1'b1);
        rd(bases[p] + OFS_WAKE_PND, 8'hFF);
        wr(bases[p] + OFS_WAKE_PND, 8'hFF);
        @(negedge core_clk);
        check_bit(wake, 1'b0);
        wr(bases[p] + OFS_WAKE_EN, 8'h00);
    endtask : wake_test

    initial
    begin
        #(25 * 5000);
        miscompares++;
        print_verdict();
    end

    initial
    begin
        {avs_read, avs_write, stx, sck_out, sck_oe} = '0;
        avs_address = 8'h00;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hF;
        bases = {BASE_G, BASE_M, BASE_L};
        drv_val = {8'h00, 8'hFF, 8'h00};
        drv_en = {8'h7F, 8'hFF, 8'hFF};
        arst_n = 1'b0;
        repeat (10) @(posedge core_clk);
        check_pin(pin_oe[2], 8'h80);
        check_pin(pin_oe[0] | pin_pu[0], 8'h00);
        arst_n <= 1'b1;
        for (int p = 0; p < 3; p++)
        begin
            m = (p == 2) ? G_DATA_MASK : 8'hFF;
            wr(bases[p] + OFS_CFG, 8'hF0);
            wr(bases[p] + OFS_DATA, 8'hCC);
            @(negedge core_clk);
            check_pin(pin_oe[p], (8'hF0 & m) | ~m & 8'h80);
            check_pin(pin_pu[p], 8'h0C);
            check_pin(pin_out[p] & 8'h30, 8'h00);
            check_pin(pin_out[p] & 8'hC0 & m, 8'hC0 & m);
            rd(bases[p] + OFS_CFG, 8'hF0);
            rd(bases[p] + OFS_DATA, 8'hCC & m);
        end
        wr(BASE_M + OFS_CFG, 8'h00);
        wr(BASE_M + OFS_DATA, 8'h00);
        drv_val[1] <= 8'hA5;
        rd(BASE_M + OFS_PINS, 8'hA5);
        drv_en[1] <= 8'h00;
        wr(BASE_M + OFS_DATA, 8'hFF);
        rd(BASE_M + OFS_PINS, 8'hFF);
        wr(BASE_M + OFS_CFG, 8'hFF);
        wr(BASE_M + OFS_DATA, 8'h3C);
        rd(BASE_M + OFS_PINS, 8'h3C);
        drv_en[1] <= 8'hFF;
        wr(BASE_G + OFS_CFG, 8'hFF);
        @(negedge core_clk);
        check_pin(pin_oe[2], 8'hBF);
        check_bit(alt_ph, 1'b1);
        check_bit(clk_dly, 1'b1);
        check_bit(pin_out[2][7], osc);
        for (int k = 0; k < 2; k++)
        begin
            m = (k == 0) ? 8'h80 : 8'h40;
            wr(BASE_G + OFS_DATA, m);
            @(negedge core_clk);
            check_bit(halt_req, m[7]);
            check_bit(idle_req, m[6]);
            @(negedge core_clk);
            check_bit(halt_req | idle_req, 1'b0);
            rd(BASE_G + OFS_DATA, 8'h00);
        end
        wr(BASE_G + OFS_CFG, 8'h00);
        @(negedge core_clk);
        check_bit(alt_ph, 1'b0);
        @(posedge core_clk);
        wake_test(0, 8'h00, 8'h00, 8'hFF);
        wake_test(1, 8'hFF, 8'hFF, 8'h00);
        wr(BASE_L + OFS_CFG, 8'hFF);
        wr(BASE_L + OFS_ALT_SEL, 8'hFF);
        rd(BASE_L + OFS_ALT_SEL, ALT_MASK);
        stx <= 1'b1;
        drv_val[0] <= 8'h0A;
        @(negedge core_clk);
        check_pin(pin_oe[0], 8'hF5);
        check_bit(pin_out[0][L_TX_BIT], 1'b1);
        check_bit(srx, 1'b1);
        check_bit(sck_pin, 1'b1);
        @(posedge core_clk);
        stx <= 1'b0;
        sck_oe <= 1'b1;
        sck_out <= 1'b1;
        @(negedge core_clk);
        check_pin(pin_oe[0], 8'hF7);
        check_pin(pin_out[0] & ALT_MASK, 8'h02);
        rd(BASE_L + OFS_PINS, 8'h0A);
        rd(8'h60, 8'h00);
        rd(BASE_G + OFS_WAKE_EN, 8'h00);
        xfer(1'b1, BASE_L + OFS_DATA, 8'h55, 4'h0);
        rd(BASE_L + OFS_DATA, 8'h00);
        print_verdict();
    end
endmodule : bidirectional_port_bank_tb
`default_nettype wire
